/* inc/ccss_map.vh */
`ifndef CCSS_MAP_VH
`define CCSS_MAP_VH
// ============================================================
// Widths
`define CCSS_PC_W      10
`define CCSS_PAGE_W    3
`define CCSS_OFS_W     7
`define CCSS_SP_W      2
`define CCSS_DATA_W    10
`define CCSS_ADDR_W    4
// ============================================================
// Register offsets
`define CCSS_REG_PORTD  4'h0
`define CCSS_REG_PORTE  4'h1
`define CCSS_REG_PORTG  4'h2
`define CCSS_REG_MODULATED_OUTPUT_PORT   4'h3
`define CCSS_REG_CSEL   4'h4
`define CCSS_REG_TCTL   4'h5
`define CCSS_REG_PDN    4'h6
`define CCSS_REG_GATE   4'h7
`define CCSS_REG_PC     4'h8
`define CCSS_REG_DP     4'h9
`define CCSS_REG_WORK   4'hA
`define CCSS_REG_BYTE   4'hB
`define CCSS_REG_TPAGE  4'hC
// ============================================================
// Opcodes
`define CCSS_OP_NOP    4'h0
`define CCSS_OP_LA     4'h1
`define CCSS_OP_LB     4'h2
`define CCSS_OP_TEAB   4'h3
`define CCSS_OP_TDA    4'h4
`define CCSS_OP_LXY    4'h5
`define CCSS_OP_INY    4'h6
`define CCSS_OP_SEA    4'h7
`define CCSS_OP_BR     4'h8
`define CCSS_OP_CALL   4'h9
`define CCSS_OP_RT     4'hA
`define CCSS_OP_RTS    4'hB
`define CCSS_OP_TABLE_READ_CALL   4'hC
// ============================================================
// Cycle counts and reset values
`define CCSS_CYC_ONE   2'h1
`define CCSS_CYC_TWO   2'h2
`define CCSS_CYC_TABLE_READ_CALL  2'h3
`define CCSS_SP_RST    2'h3
`define CCSS_SP_BACKUP 2'h3
`define CCSS_ZERO10    10'h000
`endif

/* core/ccss_core.v */
`timescale 1ns/1ns
// Contract
// RULE_01: The program counter is 10 bits, a 3-bit page over a 7-bit offset.
// RULE_02: The return stack has four 10-bit entries indexed by a 2-bit stack pointer.
// RULE_03: The 6-bit data pointer is the 2-bit upper index joined to the 4-bit lower index.
// RULE_04: There are two 4-bit working registers, an 8-bit byte latch and a 3-bit table page.
// RULE_05: There are an 8-bit port, a 3-bit port, a 4-bit port and a 1-bit modulated port.
// RULE_06: Carrier select, timer control and pull-down control are 3 bits, gate select 2 bits.
// RULE_07: A taken skip nullifies the next instruction rather than adding two to the counter.
// RULE_08: A nullified instruction takes as many cycles as if it had executed.
// RULE_09: A nullified table read call, return or return-and-skip takes one cycle only.
// RULE_10: After reset a port stays undriven until software writes zero to its latch.
// RULE_11: Software should rewrite the port latches now and then against corruption.
// RULE_12: Software stops the first timer before changing its count source.
// RULE_13: Software avoids writing the reload value at the first timer's underflow.
// RULE_14: Program flow never takes the counter past the last implemented page.
// RULE_15: Entering back-up sets the stack pointer to 3, keeping RAM and pull-down control.
// RULE_16: A true test sets a pending skip, cleared once the next slot is nullified.
`include "ccss_map.vh"

module ccss_core
(
	// Clock, reset, enable
	input  wire                      clk,
	input  wire                      srst,
	input  wire                      ce,
	// Instruction slot
	input  wire                      instr_valid,
	input  wire [3:0]                instr_op,
	input  wire [9:0]                instr_arg,
	output wire                      instr_ready,
	output reg  [`CCSS_PC_W-1:0]     program_counter,
	output wire [`CCSS_PC_W-1:0]     table_addr,
	input  wire [7:0]                rom_data,
	input  wire                      backup_enter,
	// Register port
	input  wire [`CCSS_ADDR_W-1:0]   reg_addr,
	input  wire [`CCSS_DATA_W-1:0]   reg_wdata,
	input  wire                      reg_we,
	input  wire                      reg_re,
	output reg  [`CCSS_DATA_W-1:0]   reg_rdata,
	// Ports
	output reg  [7:0]                port_d_out,
	output reg                       port_d_oe,
	output reg  [2:0]                port_e_out,
	output reg                       port_e_oe,
	output reg  [3:0]                port_g_out,
	output reg                       port_g_oe,
	output reg                       modulated_output_port,
	output reg                       modulated_output_oe,
	// Control registers
	output reg  [2:0]                carrier_select,
	output reg  [2:0]                timer_control_bits,
	output reg  [2:0]                pulldown_control,
	output reg  [1:0]                gate_function_select
);

	// ============================================================
	// Core state
	reg  [`CCSS_PC_W-1:0] return_address_stack [0:3];            // RULE_02
	reg  [`CCSS_SP_W-1:0] stack_pointer;
	reg  [1:0]            index_upper;
	reg  [3:0]            index_lower;
	reg  [3:0]            acc;
	reg  [3:0]            acc_b;
	reg  [7:0]            byte_wide_latch;
	reg  [2:0]            table_page_register;
	reg                   skip_pending;
	reg  [1:0]            busy_cnt;
	reg                   table_read_call_load;
	wire [5:0]            data_pointer;
	wire [`CCSS_PC_W-1:0] pc_next;
	wire [`CCSS_SP_W-1:0] sp_up;
	wire                  take;
	reg  [1:0]            op_cycles;
	reg  [1:0]            null_cycles;

	assign data_pointer = {index_upper, index_lower};                // RULE_03
	// Page bits roll over into the next page on purpose; staying in range is software's job.
	assign pc_next      = program_counter + 10'h001;                  // RULE_01
	assign sp_up        = stack_pointer + 2'h1;
	assign instr_ready  = (busy_cnt == 2'h0);
	assign take         = ce & instr_valid & instr_ready;
	assign table_addr   = {instr_arg[`CCSS_PAGE_W-1:0], table_page_register, acc};

	// ============================================================
	// Cycle accounting
	always @*
	begin
		case (instr_op)
			`CCSS_OP_CALL: op_cycles = `CCSS_CYC_TWO;
			`CCSS_OP_RT:   op_cycles = `CCSS_CYC_TWO;
			`CCSS_OP_RTS:  op_cycles = `CCSS_CYC_TWO;
			`CCSS_OP_TABLE_READ_CALL: op_cycles = `CCSS_CYC_TABLE_READ_CALL;
			default:       op_cycles = `CCSS_CYC_ONE;
		endcase
		null_cycles = op_cycles;                                     // RULE_08
		if (instr_op == `CCSS_OP_RT || instr_op == `CCSS_OP_RTS ||
		    instr_op == `CCSS_OP_TABLE_READ_CALL)
		begin
			null_cycles = `CCSS_CYC_ONE;                             // RULE_09
		end
	end

	// ============================================================
	// Sequencer
	always @(posedge clk)
	begin
		if (srst)
		begin
			program_counter     <= `CCSS_ZERO10;
			stack_pointer       <= `CCSS_SP_RST;
			index_upper         <= 2'h0;
			index_lower         <= 4'h0;
			acc                 <= 4'h0;
			acc_b               <= 4'h0;
			byte_wide_latch     <= 8'h00;
			table_page_register <= 3'h0;
			skip_pending        <= 1'b0;
			busy_cnt            <= 2'h0;
			table_read_call_load           <= 1'b0;
		end
		else if (ce)
		begin
			if (backup_enter)
			begin
				// Return address state is lost in back-up; RAM lives outside this block.
				program_counter <= `CCSS_ZERO10;
				stack_pointer   <= `CCSS_SP_BACKUP;                  // RULE_15
				skip_pending    <= 1'b0;
				busy_cnt        <= 2'h0;
				table_read_call_load       <= 1'b0;
			end
			else if (take && skip_pending)
			begin
				// The slot is spent; only the counter, the pending skip and the busy count change.
				program_counter <= pc_next;                          // RULE_07
				skip_pending    <= 1'b0;                             // RULE_16
				busy_cnt        <= null_cycles - 2'h1;               // RULE_08
			end
			else if (take)
			begin
				busy_cnt        <= op_cycles - 2'h1;
				program_counter <= pc_next;
				case (instr_op)
					`CCSS_OP_LA:   acc <= instr_arg[3:0];
					`CCSS_OP_LB:   acc_b <= instr_arg[3:0];
					`CCSS_OP_TEAB: byte_wide_latch <= {acc_b, acc};  // RULE_04
					`CCSS_OP_TDA:  table_page_register <= acc[2:0];
					`CCSS_OP_LXY:
					begin
						index_upper <= instr_arg[5:4];
						index_lower <= instr_arg[3:0];
					end
					`CCSS_OP_INY:  index_lower <= index_lower + 4'h1;
					`CCSS_OP_SEA:  skip_pending <= (acc == instr_arg[3:0]); // RULE_16
					`CCSS_OP_BR:   program_counter <= instr_arg;
					`CCSS_OP_CALL:
					begin
						stack_pointer                <= sp_up;
						return_address_stack[sp_up]  <= pc_next;     // RULE_02
						program_counter              <= instr_arg;
					end
					`CCSS_OP_RT:
					begin
						program_counter <= return_address_stack[stack_pointer];
						stack_pointer   <= stack_pointer - 2'h1;
					end
					`CCSS_OP_RTS:
					begin
						program_counter <= return_address_stack[stack_pointer];
						stack_pointer   <= stack_pointer - 2'h1;
						skip_pending    <= 1'b1;                     // RULE_07
					end
					`CCSS_OP_TABLE_READ_CALL: table_read_call_load <= 1'b1;
					default:       acc <= acc;
				endcase
			end
			else
			begin
				if (busy_cnt != 2'h0)
				begin
					busy_cnt <= busy_cnt - 2'h1;
				end
				// Table data is taken in the last busy cycle, when the memory has settled.
				if (table_read_call_load && busy_cnt == 2'h1)
				begin
					acc_b     <= rom_data[7:4];
					acc       <= rom_data[3:0];
					table_read_call_load <= 1'b0;
				end
			end
		end
	end

	// ============================================================
	// Register port
	always @(posedge clk)
	begin
		if (srst)
		begin
			port_d_out            <= 8'h00;
			port_d_oe             <= 1'b0;
			port_e_out            <= 3'h0;
			port_e_oe             <= 1'b0;
			port_g_out            <= 4'h0;
			port_g_oe             <= 1'b0;
			modulated_output_port <= 1'b0;
			modulated_output_oe   <= 1'b0;
			carrier_select        <= 3'h0;
			timer_control_bits    <= 3'h0;
			pulldown_control      <= 3'h0;
			gate_function_select  <= 2'h0;
			reg_rdata             <= `CCSS_ZERO10;
		end
		else if (ce)
		begin
			if (backup_enter)
			begin
				// Pull-down, carrier select, modulated port and output enables survive back-up; ports D, E, G, timer control and gate select start over.
				port_d_out           <= 8'h00;
				port_e_out           <= 3'h0;
				port_g_out           <= 4'h0;
				timer_control_bits   <= 3'h0;
				gate_function_select <= 2'h0;                        // RULE_15
			end
			else if (reg_we)
			begin
				case (reg_addr)
					`CCSS_REG_PORTD:
					begin
						port_d_out <= reg_wdata[7:0];                // RULE_05
						if (reg_wdata[7:0] == 8'h00) port_d_oe <= 1'b1; // RULE_10
					end
					`CCSS_REG_PORTE:
					begin
						port_e_out <= reg_wdata[2:0];
						if (reg_wdata[2:0] == 3'h0) port_e_oe <= 1'b1; // RULE_10
					end
					`CCSS_REG_PORTG:
					begin
						port_g_out <= reg_wdata[3:0];
						if (reg_wdata[3:0] == 4'h0) port_g_oe <= 1'b1; // RULE_10
					end
					`CCSS_REG_MODULATED_OUTPUT_PORT:
					begin
						modulated_output_port <= reg_wdata[0];
						if (!reg_wdata[0]) modulated_output_oe <= 1'b1; // RULE_10
					end
					`CCSS_REG_CSEL: carrier_select       <= reg_wdata[2:0]; // RULE_06
					`CCSS_REG_TCTL: timer_control_bits   <= reg_wdata[2:0];
					`CCSS_REG_PDN:  pulldown_control     <= reg_wdata[2:0];
					`CCSS_REG_GATE: gate_function_select <= reg_wdata[1:0];
					default:        carrier_select       <= carrier_select;
				endcase
			end
			if (reg_re)
			begin
				case (reg_addr)
					`CCSS_REG_PORTD: reg_rdata <= {2'h0, port_d_out};
					`CCSS_REG_PORTE: reg_rdata <= {7'h00, port_e_out};
					`CCSS_REG_PORTG: reg_rdata <= {6'h00, port_g_out};
					`CCSS_REG_MODULATED_OUTPUT_PORT:  reg_rdata <= {9'h000, modulated_output_port};
					`CCSS_REG_CSEL:  reg_rdata <= {7'h00, carrier_select};
					`CCSS_REG_TCTL:  reg_rdata <= {7'h00, timer_control_bits};
					`CCSS_REG_PDN:   reg_rdata <= {7'h00, pulldown_control};
					`CCSS_REG_GATE:  reg_rdata <= {8'h00, gate_function_select};
					`CCSS_REG_PC:    reg_rdata <= program_counter;
					`CCSS_REG_DP:    reg_rdata <= {skip_pending, stack_pointer, 1'b0, data_pointer};
					`CCSS_REG_WORK:  reg_rdata <= {2'h0, acc_b, acc};
					`CCSS_REG_BYTE:  reg_rdata <= {2'h0, byte_wide_latch};
					`CCSS_REG_TPAGE: reg_rdata <= {7'h00, table_page_register};
					default:         reg_rdata <= `CCSS_ZERO10;
				endcase
			end
			else
			begin
				reg_rdata <= `CCSS_ZERO10;
			end
		end
	end

endmodule

/* tb/ccss_core_assertions.sv */
`timescale 1ns/1ns
`include "ccss_map.vh"
// ==========
// Checker
module ccss_chk
(
	// Clock and reset
	input wire       clk,
	input wire       srst,
	input wire       ce,
	// Instruction slot
	input wire       instr_valid,
	input wire [3:0] instr_op,
	input wire       instr_ready,
	input wire [9:0] program_counter,
	input wire       backup_enter,
	// Register port and outputs
	input wire [3:0] reg_addr,
	input wire [9:0] reg_wdata,
	input wire       reg_we,
	input wire       port_d_oe,
	input wire [2:0] pulldown_control
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// Back-up beats an issue, so it is kept out of every issue condition.
	wire iss = ce && instr_valid && instr_ready && !backup_enter;
	// A write in the back-up cycle is dropped, so it cannot enable the port.
	wire clr = ce && reg_we && !backup_enter && reg_addr == 4'h0 && reg_wdata[7:0] == 8'h00;
	pc_step_a:
	assert property (iss && instr_op < `CCSS_OP_BR |=>
		program_counter == $past(program_counter) + 10'h001)
		else $error("counter did not step by one");
	one_cycle_a:
	assert property (iss && instr_op <= `CCSS_OP_BR |=> instr_ready) else $error("slot too long");
	call_cycles_a:
	assert property (iss && instr_op == `CCSS_OP_CALL ##1 ce |-> !instr_ready ##1 instr_ready)
		else $error("call not two cycles");
	table_cycles_a:
	assert property (iss && instr_op == `CCSS_OP_TABLE_READ_CALL ##1 (ce && !instr_ready && !backup_enter)
		|=> !instr_ready) else $error("table read not three cycles");
	ret_cycles_a:
	assert property (iss && instr_op[3:1] == 3'h5 ##1 (ce && !instr_valid) |=> instr_ready)
		else $error("return too long");
	oe_set_a:
	assert property (clr |=> port_d_oe) else $error("zero write did not enable port");
	oe_cause_a:
	assert property ($rose(port_d_oe) |-> $past(clr)) else $error("port enabled without zero");
	oe_hold_a:
	assert property (port_d_oe |=> port_d_oe) else $error("port enable dropped");
	backup_pc_a:
	assert property (ce && backup_enter |=> program_counter == 10'h000) else $error("back-up pc");
	backup_pdn_a:
	assert property (ce && backup_enter && !(reg_we && reg_addr == 4'h6) |=> $stable(pulldown_control))
		else $error("pull-down lost");
endmodule
bind ccss_core ccss_chk ccss_chk_i (
	.clk              (clk),
	.srst             (srst),
	.ce               (ce),
	.instr_valid      (instr_valid),
	.instr_op         (instr_op),
	.instr_ready      (instr_ready),
	.program_counter  (program_counter),
	.backup_enter     (backup_enter),
	.reg_addr         (reg_addr),
	.reg_wdata        (reg_wdata),
	.reg_we           (reg_we),
	.port_d_oe        (port_d_oe),
	.pulldown_control (pulldown_control)
);

/* tb/test_cpu_core_state_and_skip.sv */
`timescale 1ns/1ns
`include "ccss_map.vh"
// ==========
// Bench
module test_cpu_core_state_and_skip;
	reg        clk, srst, ce, valid, we, re, bk;
	reg  [3:0] op, ra;
	reg  [9:0] arg, wd, g;
	reg  [7:0] rom;
	wire       rdy, pdo, peo, pgo, mo, moe;
	wire [9:0] pc, rdat, ta;
	wire [7:0] pd;
	wire [2:0] pe, cs, tc, pdn;
	wire [3:0] pg;
	wire [1:0] gs;
	wire [3:0] oev = {moe, pgo, peo, pdo};
	integer    miscompares = 0, n_tests = 0, seed = 53, cyc = 0, i, n, o, c;
	integer    a, b, x, y, sk, sp, dep, epc, tp, eb;
	integer    stk [0:3];
	integer    msk [0:7];
	ccss_core ccss_core_i (.clk(clk), .srst(srst), .ce(ce), .instr_valid(valid), .instr_op(op),
		.instr_arg(arg), .instr_ready(rdy), .program_counter(pc), .table_addr(ta), .rom_data(rom),
		.backup_enter(bk), .reg_addr(ra), .reg_wdata(wd), .reg_we(we), .reg_re(re),
		.reg_rdata(rdat), .port_d_out(pd), .port_d_oe(pdo), .port_e_out(pe), .port_e_oe(peo),
		.port_g_out(pg), .port_g_oe(pgo), .modulated_output_port(mo), .modulated_output_oe(moe),
		.carrier_select(cs), .timer_control_bits(tc), .pulldown_control(pdn),
		.gate_function_select(gs));
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task end_of_test;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (cyc == 40000)
		begin
			miscompares = miscompares + 1;
			end_of_test;
		end
	end
	function [9:0] outsel(input integer k);
		case (k)
			0: outsel = pd;
			1: outsel = pe;
			2: outsel = pg;
			3: outsel = mo;
			4: outsel = cs;
			5: outsel = tc;
			6: outsel = pdn;
			7: outsel = gs;
			default: outsel = 10'h000;
		endcase
	endfunction
	task chk(input [9:0] gv, input [9:0] ev);
		n_tests = n_tests + 1;
		if (gv !== ev)
		begin
			miscompares = miscompares + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, gv, ev);
		end
	endtask
	task wr(input [3:0] ad, input [9:0] d);
		@(posedge clk);
		we <= 1;
		ra <= ad;
		wd <= d;
		@(posedge clk);
		we <= 0;
		#1;
	endtask
	task rd(input [3:0] ad, input [9:0] ev);
		@(posedge clk);
		re <= 1;
		ra <= ad;
		@(posedge clk);
		re <= 0;
		#1 chk(rdat, ev);
	endtask
	// The design runs the slot first and the model steps after it from its own state, so expectations never lean on the design's outputs.
	task exe(input [3:0] oi, input [9:0] ag);
		@(posedge clk);
		valid <= 1;
		op <= oi;
		arg <= ag;
		rom <= $random(seed);
		@(posedge clk);
		valid <= 0;
		#1;
		if (oi == 12) chk(ta, {ag[2:0], tp[2:0], a[3:0]});
		c = 1;
		epc = (epc + 1) % 1024;
		if (sk)
		begin
			c = (oi == 9) ? 2 : 1;
			sk = 0;
		end
		else
			case (oi)
				1: a = ag[3:0];
				2: b = ag[3:0];
				3: eb = b * 16 + a;
				4: tp = a % 8;
				5: begin x = ag[5:4]; y = ag[3:0]; end
				6: y = (y + 1) % 16;
				7: sk = (a == ag[3:0]);
				8: epc = ag;
				9: begin c = 2; sp = (sp + 1) % 4; stk[sp] = epc; epc = ag; end
				10, 11: begin c = 2; epc = stk[sp]; sp = (sp + 3) % 4; sk = (oi == 11); end
				12: begin c = 3; a = rom % 16; b = rom / 16; end
			endcase
		n = 0;
		while (rdy !== 1'b1 && n < 9)
		begin
			@(posedge clk);
			#1 n = n + 1;
		end
		chk(n, c - 1);
		chk(pc, epc);
	endtask
	initial
	begin
		{srst, valid, we, re, bk} = 5'h10;
		ce = 1;
		{op, arg, ra, wd, rom} = 0;
		{a, b, x, y, sk, dep, epc, tp, eb} = 0;
		sp = 3;
		msk[0] = 255;
		msk[1] = 7;
		msk[2] = 15;
		msk[3] = 1;
		msk[4] = 7;
		msk[5] = 7;
		msk[6] = 7;
		msk[7] = 3;
		repeat (10) @(posedge clk);
		srst <= 0;
		for (i = 0; i < 16; i = i + 1)
			rd(i, i == 9 ? 10'h180 : 10'h000);
		chk(oev, 0);
		for (i = 0; i < 4; i = i + 1)
		begin
			o = ($random(seed) & msk[i]) | 1;
			wr(i, o);
			chk(oev[i], 0);
			wr(i, 0);
			chk(oev[i], 1);
			wr(i, o);
			rd(i, o);
			chk(outsel(i), o);
		end
		for (i = 4; i < 8; i = i + 1)
		begin
			o = $random(seed) & msk[i];
			// Each register goes to zero before its new value, so timer control is zero just before its own change; reset zero covers the carrier select change.
			wr(i, 0);
			wr(i, o);
			rd(i, o);
			chk(outsel(i), o);
		end
		wr(8, 10'h3FF);
		rd(8, epc);
		for (i = 0; i < 400; i = i + 1)
		begin
			o = {$random(seed)} % 13;
			if (o[3:1] == 5 && dep == 0) o = 9;
			if (o == 9 && dep == 4) o = 0;
			if (epc > 1000 && !sk) o = 8;
			if (!sk) dep = dep + (o == 9) - (o == 10 || o == 11);
			g = $random(seed);
			if (o == 8 || o == 9) g[9] = 1'b0;
			if (o == 7 && g[9]) g[3:0] = a;
			exe(o, g);
			rd(9, {sk[0], sp[1:0], 1'b0, x[1:0], y[3:0]});
			rd(10, b * 16 + a);
			rd(11, eb);
			rd(12, tp);
			if (i % 100 == 99)
			begin
				@(posedge clk);
				ce <= 0;
				valid <= 1;
				op <= 4'h8;
				arg <= 10'h000;
				repeat (3) @(posedge clk);
				ce <= 1;
				valid <= 0;
				#1 chk(pc, epc);
				wr(0, 0);
				wr(6, 5);
				@(posedge clk);
				bk <= 1;
				@(posedge clk);
				bk <= 0;
				#1 {epc, sk, dep} = 0;
				sp = 3;
				chk(pc, 0);
				chk(pdn, 5);
				chk(oev, 4'hF);
				rd(9, {3'h3, 1'b0, x[1:0], y[3:0]});
				rd(0, 0);
				rd(5, 0);
				rd(7, 0);
			end
		end
		end_of_test;
	end
endmodule
